/* bench/hpl_dev_model.sv */
// Behavioural device model answering host packets over the serial link
`timescale 1ns/10ps
`default_nettype none
module hpl_dev_model #(
    parameter logic [15:0] DIV_SLOW = hpl_pkg::DIV_SLOW,
    parameter logic [15:0] DIV_FAST = hpl_pkg::DIV_FAST
) (
    // Clock and rate
    input wire logic clk,
    input wire logic fast,
    // Serial pins
    input wire logic rxd,
    output logic txd
);
    int mode = 0;
    int seen = 0;
    int lag = 0;
    logic [7:0] got [$];
    logic [7:0] rq_t = 8'h00;
    logic [4:0] rq_l = 5'h00;
    logic rq_bad = 1'b0;
    logic rq_go = 1'b0;
    logic [143:0] rq_d = 144'h0;
    logic busy = 1'b0;
    logic [15:0] div;

    assign div = fast ? DIV_FAST : DIV_SLOW;

    initial txd = 1'b1;

    function automatic logic [15:0] crc_add(input logic [15:0] c,
                                            input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        end
        return c;
    endfunction : crc_add

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            txd <= f[i];
            repeat (div) @(posedge clk);
        end
    endtask : send_byte

    // A set bad flag spoils the check value on purpose
    task automatic send_pkt(input logic [7:0] t, input logic [4:0] l,
                            input logic [143:0] d, input logic bad);
        logic [7:0] b [$];
        logic [15:0] c;
        while (busy) @(posedge clk);
        busy = 1'b1;
        b.push_back(t);
        b.push_back({3'h0, l});
        for (int i = 0; i < l; i++) b.push_back(d[8*i +: 8]);
        c = 16'hffff;
        foreach (b[i]) c = crc_add(c, b[i]);
        c = ~c ^ {15'h0, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) send_byte(b[i]);
        busy = 1'b0;
    endtask : send_pkt

    task automatic get_byte(output logic [7:0] b);
        while (rxd !== 1'b0) @(posedge clk);
        repeat (div / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge clk);
            b[i] = rxd;
        end
        repeat (div) @(posedge clk);
    endtask : get_byte

    // Unsolicited packet, independent of command timing
    initial begin : side_tx
        forever begin
            @(posedge clk);
            if (rq_go) begin
                rq_go = 1'b0;
                send_pkt(rq_t, rq_l, rq_d, rq_bad);
            end
        end
    end

    initial begin : rx_loop
        logic [7:0] pkt [$];
        logic [7:0] b;
        logic [15:0] c;
        logic [143:0] d;
        int need;
        forever begin
            pkt.delete();
            need = 2;
            while (pkt.size() < need) begin
                get_byte(b);
                got.push_back(b);
                pkt.push_back(b);
                if (pkt.size() == 2) need = pkt[1] + 4;
            end
            c = 16'hffff;
            for (int i = 0; i < need - 2; i++) c = crc_add(c, pkt[i]);
            if ({pkt[need-1], pkt[need-2]} === ~c) begin
                seen++;
                d = 144'h0;
                for (int i = 0; i < pkt[1]; i++) d[8*i +: 8] = pkt[i+2];
                repeat (lag) @(posedge clk);
                case (mode)
                    0: send_pkt(pkt[0] | 8'h40, pkt[1][4:0], d, 1'b0);
                    1: send_pkt(pkt[0] | 8'hc0, 5'h00, d, 1'b0);
                    2: if (seen > 1) send_pkt(pkt[0] | 8'h40, 5'h00, d, 1'b0);
                    default: ;
                endcase
            end
        end
    end
endmodule : hpl_dev_model
`default_nettype wire

/* bench/test_hpl_host_link.sv */
// Self-checking bench for the host packet link against a device model
`timescale 1ns/10ps
`default_nettype none
module test_hpl_host_link;
    typedef struct {
        logic [2:0] kind;
        logic [7:0] t;
        logic [4:0] l;
        logic [143:0] d;
    } hpl_note_s;
    hpl_note_s notes [$];
    int fails = 0;
    int checks = 0;
    int seed = 33986;
    // Short fast bit period keeps the run brief
    localparam logic [15:0] div_sim = 16'h0010;
    logic clk_sys, rst_n, baud_fast, cmd_valid, mute, dev_fast;
    logic [7:0] cmd_type;
    logic [4:0] cmd_len;
    logic [143:0] cmd_data;
    logic fast_rate, cmd_ready, ack_valid, rpt_valid, fault;
    logic rxd, txd, dev_rxd;
    logic [7:0] pkt_type;
    logic [4:0] pkt_len;
    logic [143:0] pkt_data;

    assign dev_rxd = txd | mute;

    hpl_host_link #(.TIMEOUT_CYCLES(4000), .RETRIES(1),
        .DIV_FAST(div_sim)) i_hpl_host_link (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .BAUD_FAST(baud_fast),
        .FAST_RATE(fast_rate), .CMD_VALID(cmd_valid), .CMD_TYPE(cmd_type),
        .CMD_LEN(cmd_len), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready),
        .ACK_VALID(ack_valid), .RPT_VALID(rpt_valid), .FAULT(fault),
        .PKT_TYPE(pkt_type), .PKT_LEN(pkt_len), .PKT_DATA(pkt_data),
        .RXD(rxd), .TXD(txd));

    hpl_dev_model #(.DIV_FAST(div_sim)) i_hpl_dev_model (.clk(clk_sys),
        .fast(dev_fast), .rxd(dev_rxd), .txd(rxd));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [159:0] seen,
                         input logic [159:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic give_up(input int n, input int lim);
        if (n >= lim) begin
            $display("BAD wait expected done seen timeout");
            fails++;
            conclude();
        end
    endtask : give_up

    task automatic do_reset();
        @(negedge clk_sys);
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
    endtask : do_reset

    // Oldest note is compared with every pulse
    always @(posedge clk_sys) begin
        hpl_note_s n;
        logic [143:0] m;
        if (rst_n === 1'b1 && {ack_valid, rpt_valid, fault} !== 3'b000) begin
            n = notes.pop_front();
            m = (144'h1 << (8 * n.l)) - 144'h1;
            check("pulse kind", {ack_valid, rpt_valid, fault}, n.kind);
            if (n.kind != 3'b001) begin
                check("packet type", pkt_type, n.t);
                check("packet length", pkt_len, n.l);
                check("payload", pkt_data & m, n.d & m);
            end
        end
    end

    // Command plus an optional concurrent packet from the device
    task automatic command(input logic [7:0] t, input logic [4:0] l,
                           input int mode, input logic [7:0] rt,
                           input logic [2:0] ak, input logic [7:0] at,
                           input logic [4:0] al);
        logic [7:0] e [$];
        logic [15:0] c;
        int n;
        int copies;
        logic [4:0] lc;
        copies = (mode >= 2) ? 2 : 1;
        lc = (l > 5'(hpl_pkg::MAX_LEN)) ? 5'(hpl_pkg::MAX_LEN) : l;
        i_hpl_dev_model.mode = mode;
        i_hpl_dev_model.seen = 0;
        i_hpl_dev_model.lag = 300;
        i_hpl_dev_model.got.delete();
        i_hpl_dev_model.rq_t = rt;
        i_hpl_dev_model.rq_l = {4'h0, rt[7]};
        i_hpl_dev_model.rq_bad = rt[6];
        i_hpl_dev_model.rq_d = 144'($random(seed));
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_type = t;
        cmd_len = l;
        for (int i = 0; i < 18; i++) cmd_data[8*i +: 8] = 8'($random(seed));
        if (rt == 8'h80) begin
            notes.push_back('{3'b010, rt, 5'h01, i_hpl_dev_model.rq_d});
        end
        notes.push_back('{ak, at, al, cmd_data});
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cmd_ready !== 1'b1 && n < 20);
        give_up(n, 20);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        check("ready while open", cmd_ready, 1'b0);
        i_hpl_dev_model.rq_go = (rt != 8'h00);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack_valid !== 1'b1 && fault !== 1'b1 && n < 20000);
        give_up(n, 20000);
        check("ready with answer", cmd_ready, 1'b1);
        c = 16'hffff;
        e.push_back(t);
        e.push_back({3'h0, lc});
        for (int i = 0; i < lc; i++) e.push_back(cmd_data[8*i +: 8]);
        foreach (e[i]) c = i_hpl_dev_model.crc_add(c, e[i]);
        e.push_back(~c[7:0]);
        e.push_back(~c[15:8]);
        n = e.size();
        check("sent count", i_hpl_dev_model.got.size(), n * copies);
        for (int k = 0; k < copies; k++) begin
            foreach (e[i]) begin
                check("sent byte", i_hpl_dev_model.got[k*n+i], e[i]);
            end
        end
    endtask : command

    initial begin : main
        int n;
        rst_n = 1'b0;
        baud_fast = 1'b0;
        cmd_valid = 1'b0;
        cmd_type = 8'h00;
        cmd_len = 5'h00;
        cmd_data = 144'h0;
        mute = 1'b1;
        dev_fast = 1'b0;
        do_reset();
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_type = 8'h01;
        n = 0;
        while (txd !== 1'b0 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        give_up(n, 100);
        n = 0;
        while (txd === 1'b0 && n < 20000) begin
            @(posedge clk_sys);
            n++;
        end
        give_up(n, 20000);
        check("start bit cycles", n, hpl_pkg::DIV_SLOW);
        check("rate after reset", fast_rate, 1'b0);
        $display("Test slow rate done");
        @(negedge clk_sys);
        baud_fast = 1'b1;
        do_reset();
        check("rate held in reset", fast_rate, 1'b0);
        mute = 1'b0;
        dev_fast = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("fast rate", fast_rate, 1'b1);
        command(8'h00, 5'h02, 0, 8'h80, 3'b100, 8'h40, 5'h02);
        $display("Test echo with report done");
        command(8'h05, 5'h03, 1, 8'h45, 3'b100, 8'hc5, 5'h00);
        $display("Test bad check value and error answer done");
        command(8'h21, 5'h1f, 2, 8'h82, 3'b100, 8'h61, 5'h00);
        $display("Test resend done");
        command(8'h01, 5'h00, 3, 8'h00, 3'b001, 8'h00, 5'h00);
        $display("Test fault done");
        repeat (10) @(negedge clk_sys);
        check("notes left", notes.size(), 0);
        conclude();
    end
endmodule : test_hpl_host_link
`default_nettype wire

/* inc/hpl_pkg.sv */
// Constants and helpers shared by the host packet link
package hpl_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int BAUD_SLOW = 19200;
    localparam int BAUD_FAST = 115200;
    localparam logic [15:0] DIV_SLOW = 16'(CLK_HZ / BAUD_SLOW);
    localparam logic [15:0] DIV_FAST = 16'(CLK_HZ / BAUD_FAST);
    localparam int FRAME_BITS = 10;
    localparam int MAX_LEN = 18;
    localparam int TIMEOUT_MS = 250;
    localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
    localparam int RETRY_MAX = 3;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [1:0] CLASS_CMD = 2'h0;
    localparam logic [1:0] CLASS_RPT = 2'h2;
    localparam logic [7:0] RPT_KEY = 8'h80;
    localparam logic [4:0] RPT_KEY_LEN = 5'h01;
    localparam logic [7:0] RPT_TEMP = 8'h82;
    localparam logic [4:0] RPT_TEMP_LEN = 5'h04;

    // One byte of the reflected CCITT CRC, low bit first
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ b[i]) begin
                r = (r >> 1) ^ CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction : crc_step

    // Fixed payload length of the known report types
    function automatic logic len_ok(input logic [7:0] t,
                                    input logic [4:0] l);
        case (t)
            RPT_KEY: len_ok = (l == RPT_KEY_LEN);
            RPT_TEMP: len_ok = (l == RPT_TEMP_LEN);
            default: len_ok = 1'b1;
        endcase
    endfunction : len_ok
endpackage : hpl_pkg

/* rtl/hpl_host_link.sv */
// Host end of the packet link: sends commands, sorts answers and reports
`timescale 1ns/10ps
`default_nettype none
module hpl_host_link #(
    parameter int TIMEOUT_CYCLES = hpl_pkg::TIMEOUT_CYC,
    parameter int RETRIES = hpl_pkg::RETRY_MAX,
    parameter logic [15:0] DIV_SLOW = hpl_pkg::DIV_SLOW,
    parameter logic [15:0] DIV_FAST = hpl_pkg::DIV_FAST
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Link speed select, taken between commands
    input wire logic BAUD_FAST,
    output logic FAST_RATE,
    // Command request
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_TYPE,
    input wire logic [4:0] CMD_LEN,
    input wire logic [143:0] CMD_DATA,
    output logic CMD_READY,
    // Acknowledge, report and fault
    output logic ACK_VALID,
    output logic RPT_VALID,
    output logic FAULT,
    output logic [7:0] PKT_TYPE,
    output logic [4:0] PKT_LEN,
    output logic [143:0] PKT_DATA,
    // Serial pins
    input wire logic RXD,
    output logic TXD
);
    typedef enum logic [2:0] {
        T_IDLE, T_TYPE, T_LEN, T_DATA, T_CRCL, T_CRCH, T_WAIT
    } hpl_tx_e;
    typedef enum logic [2:0] {
        R_TYPE, R_LEN, R_DATA, R_CRCL, R_CRCH
    } hpl_rx_e;
    typedef struct packed {
        hpl_tx_e tst;
        logic rdy;
        logic fast;
        logic tv;
        logic [7:0] tb;
        logic [15:0] tcrc;
        logic [4:0] tidx;
        logic [7:0] ctype;
        logic [4:0] clen;
        logic [17:0][7:0] cbuf;
        logic [31:0] wcnt;
        logic [3:0] tries;
        hpl_rx_e rst;
        logic [15:0] rcrc;
        logic [7:0] rtype;
        logic [4:0] rlen;
        logic [4:0] ridx;
        logic [7:0] rlo;
        logic [17:0][7:0] rbuf;
        logic ackv;
        logic rptv;
        logic fault;
        logic [7:0] otype;
        logic [4:0] olen;
        logic [17:0][7:0] odata;
    } hpl_state_s;
    hpl_state_s s;
    hpl_state_s next_s;

    logic tx_rdy;
    logic rx_v;
    logic [7:0] rx_d;
    logic [15:0] div;
    logic tx_fire;
    logic [7:0] tx_byte;
    logic matched;

    assign div = s.fast ? DIV_FAST : DIV_SLOW;
    assign tx_fire = s.tv && tx_rdy;
    assign FAST_RATE = s.fast;
    assign CMD_READY = s.rdy;
    assign ACK_VALID = s.ackv;
    assign RPT_VALID = s.rptv;
    assign FAULT = s.fault;
    assign PKT_TYPE = s.otype;
    assign PKT_LEN = s.olen;
    assign PKT_DATA = s.odata;

    hpl_uart_tx u_tx (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .div(div),
        .valid(s.tv),
        .data(s.tb),
        .ready(tx_rdy),
        .txd(TXD)
    );

    hpl_uart_rx u_rx (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .div(div),
        .rxd(RXD),
        .valid(rx_v),
        .data(rx_d)
    );

    // Byte presented in each send state
    always_comb begin
        case (s.tst)
            T_TYPE: tx_byte = s.ctype;
            T_LEN: tx_byte = {3'h0, s.clen};
            T_DATA: tx_byte = s.cbuf[s.tidx];
            T_CRCL: tx_byte = ~s.tcrc[7:0];
            T_CRCH: tx_byte = ~s.tcrc[15:8];
            default: tx_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.ackv = 1'b0;
        next_s.rptv = 1'b0;
        next_s.fault = 1'b0;
        matched = 1'b0;

        // Receive path, one byte per cycle, sorted by type
        if (rx_v) begin
            case (s.rst)
                R_TYPE: begin
                    next_s.rtype = rx_d;
                    next_s.rcrc = hpl_pkg::crc_step(hpl_pkg::CRC_INIT, rx_d);
                    next_s.rst = R_LEN;
                end
                R_LEN: begin
                    if (rx_d > 8'(hpl_pkg::MAX_LEN)) begin
                        next_s.rst = R_TYPE;
                    end else begin
                        next_s.rlen = rx_d[4:0];
                        next_s.ridx = 5'h00;
                        next_s.rcrc = hpl_pkg::crc_step(s.rcrc, rx_d);
                        next_s.rst = (rx_d == 8'h00) ? R_CRCL : R_DATA;
                    end
                end
                R_DATA: begin
                    next_s.rbuf[s.ridx] = rx_d;
                    next_s.rcrc = hpl_pkg::crc_step(s.rcrc, rx_d);
                    next_s.ridx = s.ridx + 5'h01;
                    if (s.ridx == s.rlen - 5'h01) begin
                        next_s.rst = R_CRCL;
                    end
                end
                R_CRCL: begin
                    next_s.rlo = rx_d;
                    next_s.rst = R_CRCH;
                end
                R_CRCH: begin
                    next_s.rst = R_TYPE;
                    if ({rx_d, s.rlo} == ~s.rcrc) begin
                        next_s.otype = s.rtype;
                        next_s.olen = s.rlen;
                        next_s.odata = s.rbuf;
                        if (s.rtype[7:6] == hpl_pkg::CLASS_RPT) begin
                            next_s.rptv = hpl_pkg::len_ok(s.rtype, s.rlen);
                        end else if (s.tst == T_WAIT
                                     && s.rtype[7:6] != hpl_pkg::CLASS_CMD
                                     && s.rtype[5:0] == s.ctype[5:0]) begin
                            matched = 1'b1;
                            next_s.ackv = 1'b1;
                        end
                    end
                end
                default: next_s.rst = R_TYPE;
            endcase
        end

        // Send path
        case (s.tst)
            T_IDLE: begin
                next_s.fast = BAUD_FAST;
                if (CMD_VALID && s.rdy) begin
                    next_s.ctype = CMD_TYPE;
                    next_s.clen = (CMD_LEN > 5'(hpl_pkg::MAX_LEN))
                        ? 5'(hpl_pkg::MAX_LEN) : CMD_LEN;
                    next_s.cbuf = CMD_DATA;
                    next_s.tries = 4'h0;
                    next_s.tcrc = hpl_pkg::CRC_INIT;
                    next_s.tst = T_TYPE;
                end
            end
            T_TYPE, T_LEN, T_DATA, T_CRCL, T_CRCH: begin
                if (!s.tv) begin
                    next_s.tv = 1'b1;
                    next_s.tb = tx_byte;
                end else if (tx_rdy) begin
                    next_s.tv = 1'b0;
                    if (s.tst == T_TYPE || s.tst == T_LEN
                        || s.tst == T_DATA) begin
                        next_s.tcrc = hpl_pkg::crc_step(s.tcrc, s.tb);
                    end
                    case (s.tst)
                        T_TYPE: next_s.tst = T_LEN;
                        T_LEN: begin
                            next_s.tidx = 5'h00;
                            next_s.tst = (s.clen == 5'h00) ? T_CRCL : T_DATA;
                        end
                        T_DATA: begin
                            next_s.tidx = s.tidx + 5'h01;
                            if (s.tidx == s.clen - 5'h01) begin
                                next_s.tst = T_CRCL;
                            end
                        end
                        T_CRCL: next_s.tst = T_CRCH;
                        default: begin
                            next_s.wcnt = 32'(TIMEOUT_CYCLES - 1);
                            next_s.tst = T_WAIT;
                        end
                    endcase
                end
            end
            T_WAIT: begin
                if (matched) begin
                    next_s.tst = T_IDLE;
                end else if (s.wcnt == 32'h0) begin
                    if (s.tries == 4'(RETRIES)) begin
                        next_s.fault = 1'b1;
                        next_s.tst = T_IDLE;
                    end else begin
                        next_s.tries = s.tries + 4'h1;
                        next_s.tcrc = hpl_pkg::CRC_INIT;
                        next_s.tst = T_TYPE;
                    end
                end else begin
                    next_s.wcnt = s.wcnt - 32'h1;
                end
            end
            default: next_s.tst = T_IDLE;
        endcase
        next_s.rdy = (next_s.tst == T_IDLE) && !(CMD_VALID && s.rdy);
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence s_len_sent;
        tx_fire && s.tst == T_LEN;
    endsequence
    sequence s_body_next;
        s.tst == T_DATA || s.tst == T_CRCL;
    endsequence

    a_rate_reset: assert property (
        !$past(RST_N) |-> !s.fast)
        else $error("link not at slow rate after reset");
    a_rate_hold: assert property (
        (s.tst != T_IDLE && $past(s.tst) != T_IDLE) |-> $stable(s.fast))
        else $error("rate changed inside a command");
    a_type_first: assert property (
        (tx_fire && s.tst == T_TYPE) |-> s.tb == s.ctype)
        else $error("first byte is not the type");
    a_len_order: assert property (
        s_len_sent |=> s_body_next)
        else $error("length not followed by payload or CRC");
    a_len_range: assert property (
        s_len_sent |-> s.tb <= 8'(hpl_pkg::MAX_LEN))
        else $error("length byte above 18");
    a_crc_low_first: assert property (
        (tx_fire && s.tst == T_CRCL) |-> s.tb == ~s.tcrc[7:0]
        ##1 (s.tst == T_CRCH)[*2])
        else $error("CRC low byte not sent first");
    a_wait_ack: assert property (
        CMD_READY |-> s.tst == T_IDLE && !s.tv)
        else $error("ready while a command is open");
    a_retry_bound: assert property (
        FAULT |-> $past(s.tries) == 4'(RETRIES) && $past(s.wcnt) == 32'h0)
        else $error("fault before all retries");
    a_report_sort: assert property (
        RPT_VALID |-> PKT_TYPE[7:6] == hpl_pkg::CLASS_RPT && !ACK_VALID
        && hpl_pkg::len_ok(PKT_TYPE, PKT_LEN))
        else $error("report not sorted by type");
    a_ack_match: assert property (
        ACK_VALID |-> PKT_TYPE[5:0] == s.ctype[5:0] && s.tst == T_IDLE)
        else $error("acknowledge type mismatch");
endmodule : hpl_host_link
`default_nettype wire

/* rtl/hpl_uart_rx.sv */
// Serial receiver, 8 data bits, no parity, 1 stop bit
`timescale 1ns/10ps
`default_nettype none
module hpl_uart_rx (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bit period in clock cycles
    input wire logic [15:0] div,
    // Line
    input wire logic rxd,
    // Byte stream
    output logic valid,
    output logic [7:0] data
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic busy;
        logic [15:0] tick;
        logic [3:0] nbit;
        logic [7:0] sh;
        logic valid;
        logic [7:0] data;
    } hpl_rx_s;
    hpl_rx_s s;
    hpl_rx_s next_s;

    assign valid = s.valid;
    assign data = s.data;

    always_comb begin
        next_s = s;
        next_s.s1 = rxd;
        next_s.s2 = s.s1;
        next_s.valid = 1'b0;
        if (!s.busy) begin
            if (!s.s2) begin
                next_s.busy = 1'b1;
                next_s.tick = div >> 1;
                next_s.nbit = 4'h9;
            end
        end else if (s.tick != 16'h0000) begin
            next_s.tick = s.tick - 16'h0001;
        end else begin
            next_s.tick = div - 16'h0001;
            next_s.nbit = s.nbit - 4'h1;
            if (s.nbit == 4'h9) begin
                // Glitch on the start bit
                next_s.busy = !s.s2;
            end else if (s.nbit != 4'h0) begin
                next_s.sh = {s.s2, s.sh[7:1]};
            end else begin
                next_s.busy = 1'b0;
                next_s.valid = s.s2;
                next_s.data = s.sh;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Line idles high, so no false start after reset
            s <= '{s1: 1'b1, s2: 1'b1, busy: 1'b0, tick: 16'h0000,
                   nbit: 4'h0, sh: 8'h00, valid: 1'b0, data: 8'h00};
        end else begin
            s <= next_s;
        end
    end

    a_rx_stop_ok: assert property (@(posedge clk) disable iff (!rst_n)
        valid |-> $past(s.s2) && !s.busy)
        else $error("byte accepted without stop bit");
endmodule : hpl_uart_rx
`default_nettype wire

/* rtl/hpl_uart_tx.sv */
// Serial transmitter, 8 data bits, no parity, 1 stop bit
`timescale 1ns/10ps
`default_nettype none
module hpl_uart_tx (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bit period in clock cycles
    input wire logic [15:0] div,
    // Byte stream
    input wire logic valid,
    input wire logic [7:0] data,
    output logic ready,
    // Line
    output logic txd
);
    typedef struct packed {
        logic [15:0] tick;
        logic [3:0] nbit;
        logic [9:0] sh;
        logic txd;
    } hpl_tx_s;
    hpl_tx_s s;
    hpl_tx_s next_s;

    assign ready = (s.nbit == 4'h0);
    assign txd = s.txd;

    always_comb begin
        next_s = s;
        if (s.nbit == 4'h0) begin
            if (valid) begin
                next_s.sh = {1'b1, data, 1'b0};
                next_s.txd = 1'b0;
                next_s.nbit = 4'(hpl_pkg::FRAME_BITS);
                next_s.tick = div - 16'h0001;
            end
        end else if (s.tick == 16'h0000) begin
            next_s.sh = {1'b1, s.sh[9:1]};
            next_s.txd = s.sh[1];
            next_s.nbit = s.nbit - 4'h1;
            next_s.tick = div - 16'h0001;
        end else begin
            next_s.tick = s.tick - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '{tick: 16'h0000, nbit: 4'h0, sh: 10'h3ff, txd: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    a_tx_start_low: assert property (@(posedge clk) disable iff (!rst_n)
        (ready && valid) |=> !txd && !ready)
        else $error("start bit not driven low");
endmodule : hpl_uart_tx
`default_nettype wire
